/* File: core/standby_ctrl_defs.svh */
// constants for the timebase-timer and watch standby controller
`ifndef STANDBY_CTRL_DEFS_SVH
`define STANDBY_CTRL_DEFS_SVH

// register byte addresses
`define LPC_ADDR        4'h0
`define CKS_ADDR        4'h4
`define STAT_ADDR       4'h8

// low_power_control_reg fields
`define LP_STOP_BIT     7
`define LP_SLEEP_BIT    6
`define LP_FLOAT_BIT    5
`define LP_WATCH_BIT    3
`define LPC_RESET       8'h08

// clock_select_reg fields (both active low selects)
`define CK_PLL_N_BIT    0
`define CK_SUB_N_BIT    1
`define CKS_RESET       8'h03

// interrupt level that never wakes the block
`define IRQ_LVL_OFF     3'h7

// clock rate and stabilization waits (least times)
`define CLK_MHZ         125
`define MAIN_WAIT_NS    131072
`define PLL_WAIT_NS     16384
`define SUB_WAIT_NS     262144
`define MAIN_WAIT_CYCLES ((`MAIN_WAIT_NS * `CLK_MHZ + 999) / 1000)
`define PLL_WAIT_CYCLES  ((`PLL_WAIT_NS * `CLK_MHZ + 999) / 1000)
`define SUB_WAIT_CYCLES  ((`SUB_WAIT_NS * `CLK_MHZ + 999) / 1000)

`endif

/* File: core/standby_ctrl_pkg.sv */
// types shared by the standby controller and its bench
package standby_ctrl_pkg;

    typedef enum logic [2:0] {
        ST_RUN       = 3'b000,
        ST_TBT       = 3'b001,
        ST_WATCH     = 3'b010,
        ST_MAIN_WAIT = 3'b011,
        ST_SUB_WAIT  = 3'b100,
        ST_PLL_WAIT  = 3'b101
    } pm_state_t;

    typedef enum logic [1:0] {
        CLK_MAIN = 2'b00,
        CLK_SUB  = 2'b01,
        CLK_PLL  = 2'b10
    } clk_mode_t;

    // wake sources with their programmed levels
    typedef struct packed {
        logic       watchReq;
        logic [2:0] watchLvl;
        logic       timebaseReq;
        logic [2:0] timebaseLvl;
        logic       extReq;
        logic [2:0] extLvl;
    } irq_src_t;

    // enables toward clock generator, timers, cpu and pads
    typedef struct packed {
        logic      cpuHalt;
        logic      periphRun;
        logic      timebaseRun;
        logic      watchRun;
        logic      mainOscEn;
        logic      subOscEn;
        logic      pllEn;
        logic      retain;
        logic      pinHold;
        logic      pinFloat;
        clk_mode_t cpuClk;
    } pm_ctl_t;

endpackage : standby_ctrl_pkg

/* File: core/standby_ctrl.sv */
// timebase-timer and watch standby controller with its registers
//
// Functional notes
// - timebase mode: oscillators on, only timebase and watch timers run
// - stop request in pll clock mode enters timebase timer mode
// - ram and cpu registers are kept through both standby modes
// - pending interrupt at entry write blocks entry, cpu evaluates it
// - pins held or floated on entry, chosen by pin_float_select
// - reset factor or interrupt ends timebase mode; reset then runs
// - external reset from timebase keeps pll select, pll after wait
// - reset sequence runs on main clock while pll still stabilizes
// - watch, timebase or external irq below level 7 ends timebase
// - after irq exit cpu accepts request or resumes next instruction
// - watch mode keeps only sub clock and watch timer running
// - clearing watch_mode_bit enters watch mode unless irq pending
// - watch variant follows entry clock mode, restored on irq exit
// - external reset does not release sub watch mode
// - sub watch ends only by ext irq, watch irq or standby release
// - standby release from sub watch: sub wait, reset on sub clock
// - ext reset from main/pll watch: main wait, pll kept, then pll
// - watch timer or external irq below level 7 ends watch mode
// - main/pll watch evaluates irq after main wait, sub at once
// - stop beats sleep; cleared watch bit beats sleep
`timescale 1ns/1ps
`include "standby_ctrl_defs.svh"

module standby_ctrl
    import standby_ctrl_pkg::*;
#(
    parameter logic [15:0] MAIN_WAIT_CYC = 16'(`MAIN_WAIT_CYCLES),
    parameter logic [15:0] PLL_WAIT_CYC  = 16'(`PLL_WAIT_CYCLES),
    parameter logic [15:0] SUB_WAIT_CYC  = 16'(`SUB_WAIT_CYCLES)
) (
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic [3:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic      [7:0] regRdata,
    input  wire irq_src_t   irqSrc,
    input  wire logic       irqPending,
    input  wire logic [2:0] pendLevel,
    input  wire logic       iFlag,
    input  wire logic [2:0] irqLevelMask,
    input  wire logic       extResetReq,
    input  wire logic       swResetReq,
    input  wire logic       standbyRelease,
    output pm_ctl_t         ctl,
    output logic            irqEval,
    output logic            irqTake,
    output logic            resumeNext,
    output logic            resetSeqStart
);

    pm_state_t   state_q, state_d;
    clk_mode_t   savedMode_q, savedMode_d, curMode, nextMode;
    logic [7:0]  lpc_q, cks_q, cks_d;
    logic [15:0] waitCnt_q, waitLoad;
    logic        loadCnt, floatSel_q, resetExit_q, resetExit_d, keepPll;
    logic        keepPllExit_q, keepPllExit_d, evalNow, rstNow, keepSub;
    logic        lpcWr, stopWr, watchWr, wakeTbt, wakeWatch, anyReset;
    logic        accept, enterStby;

    // a level of 7 means the source may not wake the block
    function automatic logic lvlOk(input logic [2:0] lvl);
        lvlOk = lvl < `IRQ_LVL_OFF;
    endfunction : lvlOk

    // clock mode implied by the active-low select bits
    function automatic clk_mode_t modeOf(input logic [7:0] cks);
        modeOf = !cks[`CK_SUB_N_BIT] ? CLK_SUB
               : (!cks[`CK_PLL_N_BIT] ? CLK_PLL : CLK_MAIN);
    endfunction : modeOf

    // request decode and wake qualification
    assign lpcWr   = regWr && (regAddr == `LPC_ADDR);
    assign stopWr  = lpcWr && regWdata[`LP_STOP_BIT];
    assign watchWr = lpcWr && !regWdata[`LP_WATCH_BIT];
    assign curMode = modeOf(cks_q);
    assign nextMode = modeOf(cks_d);
    assign anyReset = extResetReq || swResetReq || standbyRelease;
    assign accept  = iFlag && (pendLevel < irqLevelMask);
    assign wakeTbt = (irqSrc.watchReq && lvlOk(irqSrc.watchLvl))
                  || (irqSrc.timebaseReq && lvlOk(irqSrc.timebaseLvl))
                  || (irqSrc.extReq && lvlOk(irqSrc.extLvl));
    assign wakeWatch = (irqSrc.watchReq && lvlOk(irqSrc.watchLvl))
                    || (irqSrc.extReq && lvlOk(irqSrc.extLvl));
    assign enterStby = (state_q == ST_RUN)
                    && ((state_d == ST_TBT) || (state_d == ST_WATCH));

    // mode sequencer: entry, cancellation and stabilization waits
    always_comb begin
        state_d       = state_q;
        savedMode_d   = savedMode_q;
        resetExit_d   = resetExit_q;
        keepPllExit_d = keepPllExit_q;
        loadCnt       = 1'b0;
        waitLoad      = 16'h0000;
        evalNow       = 1'b0;
        rstNow        = 1'b0;
        keepPll       = 1'b0;
        keepSub       = 1'b0;
        case (state_q)
            ST_RUN: begin
                // watch bit checked first so it wins over stop
                if (watchWr) begin
                    if (irqPending) begin
                        evalNow = 1'b1;
                    end else begin
                        state_d     = ST_WATCH;
                        savedMode_d = curMode;
                    end
                end else if (stopWr && (curMode == CLK_PLL)) begin
                    if (irqPending) begin
                        evalNow = 1'b1;
                    end else begin
                        state_d     = ST_TBT;
                        savedMode_d = curMode;
                    end
                end
            end
            ST_TBT: begin
                if (extResetReq) begin
                    rstNow   = 1'b1;
                    keepPll  = 1'b1;
                    state_d  = ST_PLL_WAIT;
                    loadCnt  = 1'b1;
                    waitLoad = PLL_WAIT_CYC - 16'h0001;
                end else if (swResetReq || standbyRelease) begin
                    rstNow  = 1'b1;
                    state_d = ST_RUN;
                end else if (wakeTbt) begin
                    evalNow = 1'b1;
                    state_d = ST_RUN;
                end
            end
            ST_WATCH: begin
                if (savedMode_q == CLK_SUB) begin
                    // external and software resets are ignored here
                    if (standbyRelease) begin
                        state_d     = ST_SUB_WAIT;
                        resetExit_d = 1'b1;
                        loadCnt     = 1'b1;
                        waitLoad    = SUB_WAIT_CYC - 16'h0001;
                    end else if (wakeWatch) begin
                        evalNow = 1'b1;
                        state_d = ST_RUN;
                    end
                end else if (anyReset || wakeWatch) begin
                    state_d       = ST_MAIN_WAIT;
                    resetExit_d   = anyReset;
                    keepPllExit_d = extResetReq;
                    loadCnt       = 1'b1;
                    waitLoad      = MAIN_WAIT_CYC - 16'h0001;
                end
            end
            ST_MAIN_WAIT: begin
                if (waitCnt_q == 16'h0000) begin
                    if (resetExit_q) begin
                        rstNow  = 1'b1;
                        keepPll = keepPllExit_q;
                    end else begin
                        evalNow = 1'b1;
                    end
                    if ((savedMode_q == CLK_PLL)
                        && (keepPllExit_q || !resetExit_q)) begin
                        state_d  = ST_PLL_WAIT;
                        loadCnt  = 1'b1;
                        waitLoad = PLL_WAIT_CYC - 16'h0001;
                    end else begin
                        state_d = ST_RUN;
                    end
                end
            end
            ST_SUB_WAIT: begin
                if (waitCnt_q == 16'h0000) begin
                    rstNow  = 1'b1;
                    keepPll = 1'b1;
                    keepSub = 1'b1;
                    state_d = ST_RUN;
                end
            end
            ST_PLL_WAIT: begin
                if (waitCnt_q == 16'h0000) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    // next clock select value, reset factors restore defaults except selects held by keepPll or keepSub
    always_comb begin
        cks_d = cks_q;
        if (rstNow) begin
            cks_d = `CKS_RESET;
            if (keepPll) begin
                cks_d[`CK_PLL_N_BIT] = cks_q[`CK_PLL_N_BIT];
            end
            if (keepSub) begin
                cks_d[`CK_SUB_N_BIT] = cks_q[`CK_SUB_N_BIT];
            end
        end else if (regWr && (regAddr == `CKS_ADDR)) begin
            cks_d[`CK_PLL_N_BIT] = regWdata[`CK_PLL_N_BIT];
            cks_d[`CK_SUB_N_BIT] = regWdata[`CK_SUB_N_BIT];
        end
    end

    // state and exit bookkeeping
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q       <= ST_RUN;
            savedMode_q   <= CLK_MAIN;
            resetExit_q   <= 1'b0;
            keepPllExit_q <= 1'b0;
        end else begin
            state_q       <= state_d;
            savedMode_q   <= savedMode_d;
            resetExit_q   <= resetExit_d;
            keepPllExit_q <= keepPllExit_d;
        end
    end

    // stabilization counter on the always-running system clock
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            waitCnt_q <= 16'h0000;
        end else if (loadCnt) begin
            waitCnt_q <= waitLoad;
        end else if (waitCnt_q != 16'h0000) begin
            waitCnt_q <= waitCnt_q - 16'h0001;
        end
    end

    // pin mode taken from the entry write itself
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            floatSel_q <= 1'b0;
        end else if (enterStby) begin
            floatSel_q <= regWdata[`LP_FLOAT_BIT];
        end
    end

    // low_power_control_reg: request bits consumed when resolved
    always_ff @(posedge clock) begin
        if (sys_rst || rstNow) begin
            lpc_q <= `LPC_RESET;
        end else if (evalNow || (state_d == ST_RUN && state_q != ST_RUN)) begin
            lpc_q[`LP_STOP_BIT]  <= 1'b0;
            lpc_q[`LP_SLEEP_BIT] <= 1'b0;
            lpc_q[`LP_WATCH_BIT] <= 1'b1;
        end else if (lpcWr) begin
            lpc_q[`LP_STOP_BIT]  <= regWdata[`LP_STOP_BIT];
            lpc_q[`LP_SLEEP_BIT] <= regWdata[`LP_SLEEP_BIT];
            lpc_q[`LP_FLOAT_BIT] <= regWdata[`LP_FLOAT_BIT];
            lpc_q[`LP_WATCH_BIT] <= regWdata[`LP_WATCH_BIT];
        end
    end

    // clock_select_reg
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cks_q <= `CKS_RESET;
        end else begin
            cks_q <= cks_d;
        end
    end

    // register read port, data one cycle after the strobe
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            regRdata <= 8'h00;
        end else if (regRd) begin
            case (regAddr)
                `LPC_ADDR:  regRdata <= lpc_q;
                `CKS_ADDR:  regRdata <= cks_q;
                `STAT_ADDR: regRdata <= {floatSel_q, ctl.cpuClk,
                                         savedMode_q, state_q};
                default:    regRdata <= 8'h00;
            endcase
        end else begin
            regRdata <= 8'h00;
        end
    end

    // cpu evaluation and reset sequence pulses
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irqEval       <= 1'b0;
            irqTake       <= 1'b0;
            resumeNext    <= 1'b0;
            resetSeqStart <= 1'b0;
        end else begin
            irqEval       <= evalNow;
            irqTake       <= evalNow && accept;
            resumeNext    <= evalNow && !accept;
            resetSeqStart <= rstNow;
        end
    end

    // enables registered from the next state
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctl <= '{cpuHalt: 1'b0, periphRun: 1'b1, timebaseRun: 1'b1,
                     watchRun: 1'b1, mainOscEn: 1'b1, subOscEn: 1'b1,
                     pllEn: 1'b0, retain: 1'b0, pinHold: 1'b0,
                     pinFloat: 1'b0, cpuClk: CLK_MAIN};
        end else begin
            ctl.cpuHalt     <= (state_d != ST_RUN)
                            && (state_d != ST_PLL_WAIT);
            ctl.periphRun   <= (state_d == ST_RUN)
                            || (state_d == ST_PLL_WAIT);
            ctl.timebaseRun <= (state_d != ST_WATCH)
                            && (state_d != ST_SUB_WAIT);
            ctl.watchRun    <= 1'b1;
            ctl.mainOscEn   <= (state_d != ST_WATCH)
                            && (state_d != ST_SUB_WAIT);
            ctl.subOscEn    <= 1'b1;
            ctl.pllEn       <= (state_d == ST_TBT)
                            || (state_d == ST_PLL_WAIT)
                            || (state_d == ST_RUN && nextMode == CLK_PLL);
            ctl.retain      <= (state_d != ST_RUN)
                            && (state_d != ST_PLL_WAIT);
            if (state_d == ST_RUN || state_d == ST_PLL_WAIT) begin
                ctl.pinHold  <= 1'b0;
                ctl.pinFloat <= 1'b0;
            end else if (enterStby) begin
                ctl.pinHold  <= !regWdata[`LP_FLOAT_BIT];
                ctl.pinFloat <= regWdata[`LP_FLOAT_BIT];
            end
            case (state_d)
                ST_RUN:      ctl.cpuClk <= nextMode;
                ST_SUB_WAIT: ctl.cpuClk <= CLK_SUB;
                ST_WATCH:    ctl.cpuClk <= CLK_SUB;
                ST_TBT:      ctl.cpuClk <= CLK_PLL;
                default:     ctl.cpuClk <= CLK_MAIN;
            endcase
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    tbt_entry_a: assert property (
        state_q == ST_RUN && stopWr && !watchWr && curMode == CLK_PLL
        && !irqPending |=> state_q == ST_TBT && ctl.cpuHalt)
        else $error("timebase entry missed");
    entry_block_a: assert property (
        state_q == ST_RUN && irqPending
        && (watchWr || (stopWr && curMode == CLK_PLL))
        |=> state_q == ST_RUN && irqEval && !ctl.cpuHalt)
        else $error("entry not blocked by pending irq");
    tbt_clocks_a: assert property (
        $past(state_q) == ST_TBT && state_q == ST_TBT
        |-> ctl.mainOscEn && ctl.subOscEn && ctl.timebaseRun
            && !ctl.periphRun && ctl.cpuHalt)
        else $error("wrong enables in timebase mode");
    watch_clocks_a: assert property (
        $past(state_q) == ST_WATCH && state_q == ST_WATCH
        |-> !ctl.mainOscEn && ctl.subOscEn && ctl.watchRun
            && !ctl.timebaseRun && !ctl.pllEn)
        else $error("wrong enables in watch mode");
    sub_ext_rst_a: assert property (
        state_q == ST_WATCH && savedMode_q == CLK_SUB && !standbyRelease
        && !wakeWatch |=> state_q == ST_WATCH)
        else $error("sub watch left without a valid cause");
    pin_float_a: assert property (
        enterStby |=> ctl.pinFloat == lpc_q[`LP_FLOAT_BIT]
                      && ctl.pinHold != ctl.pinFloat)
        else $error("pin mode not taken at entry");
    sub_wake_a: assert property (
        state_q == ST_WATCH && savedMode_q == CLK_SUB && wakeWatch
        && !standbyRelease |=> state_q == ST_RUN && irqEval)
        else $error("sub watch wake not evaluated at once");
    main_wait_a: assert property (
        state_q == ST_MAIN_WAIT && waitCnt_q != 16'h0000
        |=> state_q == ST_MAIN_WAIT && !irqEval
            && waitCnt_q == $past(waitCnt_q) - 16'h0001)
        else $error("main wait cut short");
    tbt_ext_rst_a: assert property (
        state_q == ST_TBT && extResetReq
        |=> state_q == ST_PLL_WAIT && resetSeqStart
            && cks_q[`CK_PLL_N_BIT] == $past(cks_q[`CK_PLL_N_BIT])
        ##1 ctl.cpuClk == CLK_MAIN)
        else $error("timebase external reset handled wrongly");
    watch_restore_a: assert property (
        state_q == ST_MAIN_WAIT && waitCnt_q == 16'h0000 && !resetExit_q
        && savedMode_q == CLK_MAIN |=> state_q == ST_RUN
        && ctl.cpuClk == CLK_MAIN && irqEval)
        else $error("main watch return mode wrong");

endmodule : standby_ctrl

/* File: testbench/cpu_irq_model.sv */
// cpu flag and interrupt source model facing the standby block
`timescale 1ns/1ps

module cpu_irq_model
    import standby_ctrl_pkg::*;
(
    input  wire logic [2:0] wakeSel,
    input  wire logic [2:0] lvl,
    input  wire logic       ien,
    input  wire logic [2:0] msk,
    output irq_src_t        irqSrc,
    output logic            irqPending,
    output logic [2:0]      pendLevel,
    output logic            iFlag,
    output logic [2:0]      irqLevelMask
);
    // sources share one level; any raised source is also pending
    always_comb begin
        irqSrc       = {wakeSel[2], lvl, wakeSel[1], lvl, wakeSel[0], lvl};
        irqPending   = |wakeSel;
        pendLevel    = lvl;
        iFlag        = ien;
        irqLevelMask = msk;
    end
endmodule : cpu_irq_model

/* File: testbench/standby_ctrl_tb_top.sv */
// self-checking bench for the standby controller
`timescale 1ns/1ps

module standby_ctrl_tb_top;
    import standby_ctrl_pkg::*;
    logic       clock, sys_rst, regWr, regRd, ien, irqPending, iFlag;
    logic       extResetReq, swResetReq, standbyRelease;
    logic       irqEval, irqTake, resumeNext, resetSeqStart;
    logic [3:0] regAddr;
    logic [7:0] regWdata, regRdata;
    logic [2:0] wakeSel, lvl, msk, pendLevel, irqLevelMask;
    irq_src_t   irqSrc;
    pm_ctl_t    ctl;
    int         n_fail, samples_checked;

    standby_ctrl #(.MAIN_WAIT_CYC(16'h4), .PLL_WAIT_CYC(16'h4),
        .SUB_WAIT_CYC(16'h4)) standby_ctrl_i (.clock(clock),
        .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irqSrc(irqSrc),
        .irqPending(irqPending), .pendLevel(pendLevel), .iFlag(iFlag),
        .irqLevelMask(irqLevelMask), .extResetReq(extResetReq),
        .swResetReq(swResetReq), .standbyRelease(standbyRelease), .ctl(ctl),
        .irqEval(irqEval), .irqTake(irqTake), .resumeNext(resumeNext),
        .resetSeqStart(resetSeqStart));
    cpu_irq_model cpu_irq_model_i (.wakeSel(wakeSel), .lvl(lvl), .ien(ien),
        .msk(msk), .irqSrc(irqSrc), .irqPending(irqPending),
        .pendLevel(pendLevel), .iFlag(iFlag), .irqLevelMask(irqLevelMask));

    // 125 MHz clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // compare and count
    task automatic chk(input string nm, input logic [7:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // wait n edges, then sample just after
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc

    // one-cycle register write
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clock);
        regWr <= 1'b0;
    endtask : wr

    // one-cycle read, masked compare in the following cycle
    task automatic rd(input logic [3:0] a, input logic [7:0] m,
                      input string nm, input logic [7:0] e);
        @(posedge clock);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRd <= 1'b0;
        #1;
        chk(nm, regRdata & m, e);
    endtask : rd

    // waits for reset-sequence or evaluation pulse, counting cycles
    task automatic waitp(input bit rs, output int n);
        n = 0;
        #1;
        while ((rs ? resetSeqStart : irqEval) !== 1'b1 && n < 100) begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask : waitp

    // drive interrupt sources and cpu acceptance
    task automatic wake(input logic [2:0] s, l, input logic e);
        @(posedge clock);
        wakeSel <= s;
        lvl     <= l;
        ien     <= e;
        msk     <= 3'h7;
    endtask : wake

    // one-cycle reset factor pulse
    task automatic pulse(input logic e, s, r);
        @(posedge clock);
        extResetReq    <= e;
        swResetReq     <= s;
        standbyRelease <= r;
        @(posedge clock);
        extResetReq    <= 1'b0;
        swResetReq     <= 1'b0;
        standbyRelease <= 1'b0;
    endtask : pulse

    // select clock mode, then request standby
    task automatic enter(input logic [7:0] cks, lpc);
        wr(4'h4, cks);
        wr(4'h0, lpc);
        cyc(2);
    endtask : enter

    // timebase entry with sleep beside stop, level 7 ignored, then wake
    task automatic t_tbt();
        int n;
        enter(8'h02, 8'hC8);
        rd(4'h8, 8'h07, "tbt state", 8'h01);
        chk("tbt run", {ctl.cpuHalt, ctl.periphRun, ctl.timebaseRun,
            ctl.watchRun, ctl.mainOscEn, ctl.subOscEn}, 8'h2F);
        chk("tbt pins", {ctl.pllEn, ctl.retain, ctl.pinHold, ctl.pinFloat},
            8'h0E);
        wake(3'b010, 3'h7, 1'b1);
        cyc(5);
        chk("tbt lvl7", ctl.cpuHalt, 1'b1);
        wake(3'b010, 3'h3, 1'b1);
        waitp(1'b0, n);
        chk("tbt wake", n < 4, 1'b1);
        chk("tbt take", {irqTake, resumeNext}, 8'h02);
        wake(3'b000, 3'h3, 1'b1);
        cyc(1);
        chk("tbt halt", ctl.cpuHalt, 1'b0);
    endtask : t_tbt

    // pending request blocks watch entry
    task automatic t_block();
        int n;
        wake(3'b100, 3'h3, 1'b0);
        wr(4'h0, 8'h00);
        waitp(1'b0, n);
        chk("blk resume", {irqTake, resumeNext}, 8'h01);
        rd(4'h8, 8'h07, "blk state", 8'h00);
        rd(4'h0, 8'hFF, "blk lpc", 8'h08);
        wake(3'b000, 3'h3, 1'b0);
    endtask : t_block

    // sub watch with floating pins, deaf to resets and timebase
    task automatic t_subw();
        int n;
        enter(8'h01, 8'h20); // shared outputs already off
        rd(4'h8, 8'h9F, "subw stat", 8'h8A);
        chk("subw run", {ctl.cpuHalt, ctl.periphRun, ctl.timebaseRun,
            ctl.watchRun, ctl.mainOscEn, ctl.subOscEn}, 8'h25);
        chk("subw float", ctl.pinFloat, 1'b1);
        pulse(1'b1, 1'b1, 1'b0);
        wake(3'b010, 3'h2, 1'b0);
        cyc(5);
        rd(4'h8, 8'h07, "subw stay", 8'h02);
        wake(3'b100, 3'h2, 1'b0);
        waitp(1'b0, n);
        chk("subw fast", n < 4, 1'b1);
        chk("subw resume", resumeNext, 1'b1);
        wake(3'b000, 3'h2, 1'b0);
        cyc(1);
        chk("subw clk", ctl.cpuClk, CLK_SUB);
    endtask : t_subw

    // main watch wake waits for the main oscillator
    task automatic t_mainw();
        int n;
        enter(8'h03, 8'h40); // sleep beside cleared watch bit
        wake(3'b100, 3'h1, 1'b1);
        waitp(1'b0, n);
        chk("mainw wait", n > 4 && n < 12, 1'b1);
        chk("mainw take", irqTake, 1'b1);
        wake(3'b000, 3'h1, 1'b1);
        cyc(1);
        chk("mainw clk", ctl.cpuClk, CLK_MAIN);
    endtask : t_mainw

    // reset factor out of a standby state, then check the clock path
    task automatic t_rst(input logic [7:0] cks, lpc, input logic e, r,
                         input int lo, input logic [1:0] c1, c2);
        int n;
        enter(cks, lpc);
        pulse(e, 1'b0, r);
        waitp(1'b1, n);
        chk("rst wait", n >= lo && n < 20, 1'b1);
        cyc(1);
        chk("rst clk", ctl.cpuClk, c1);
        cyc(9);
        chk("rst final", ctl.cpuClk, c2);
        rd(4'h4, 8'h03, "rst cks", cks);
    endtask : t_rst

    // verdict and end of run
    task automatic end_sim();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    // watchdog against a hang
    initial begin
        repeat (5000) @(posedge clock);
        n_fail++;
        end_sim();
    end

    // main sequence
    initial begin
        {sys_rst, regWr, regRd, extResetReq, swResetReq} = 5'h10;
        {standbyRelease, ien, wakeSel, lvl, msk, regAddr} = 15'h0;
        {regWdata, n_fail, samples_checked} = '0;
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        rd(4'h0, 8'hFF, "lpc rst", 8'h08);
        rd(4'h4, 8'hFF, "cks rst", 8'h03);
        rd(4'hC, 8'hFF, "unmapped", 8'h00);
        t_tbt();
        t_block();
        t_subw();
        t_mainw();
        // timebase mode left by an external reset
        t_rst(8'h02, 8'h88, 1'b1, 1'b0, 0, CLK_MAIN, CLK_PLL);
        wr(4'h4, 8'h03); // back to main clock
        t_rst(8'h02, 8'h00, 1'b1, 1'b0, 4, CLK_MAIN, CLK_PLL);
        t_rst(8'h01, 8'h00, 1'b0, 1'b1, 4, CLK_SUB, CLK_SUB);
        end_sim();
    end
endmodule : standby_ctrl_tb_top
